// ### core/lmc_defines.vh
`ifndef LMC_DEFINES_VH
`define LMC_DEFINES_VH

`define LMC_ADDR_W 16
`define LMC_BASE 16'h8000
`define LMC_REG_CNT 33
`define LMC_IDX_W 6
`define LMC_IDX_LAST 6'h20

`define LMC_IDX_MEMCFG 6'h00
`define LMC_IDX_ROW_BYTES 6'h04
`define LMC_IDX_FRAME_H 6'h05
`define LMC_IDX_RANGE_LO 6'h06
`define LMC_IDX_RANGE_HI 6'h07
`define LMC_IDX_PWR_SAVE 6'h08
`define LMC_IDX_DISP_EN 6'h09
`define LMC_IDX_B1_LO 6'h0b
`define LMC_IDX_B1_HI 6'h0c
`define LMC_IDX_B1_SIZE 6'h0d
`define LMC_IDX_B2_LO 6'h0e
`define LMC_IDX_B2_HI 6'h0f
`define LMC_IDX_B2_SIZE 6'h10
`define LMC_IDX_B3_LO 6'h11
`define LMC_IDX_B3_HI 6'h12
`define LMC_IDX_B4_LO 6'h13
`define LMC_IDX_B4_HI 6'h14
`define LMC_IDX_CURS_LO 6'h1c
`define LMC_IDX_CURS_HI 6'h1d
`define LMC_IDX_SCROLL 6'h1b

`define LMC_MEMCFG_RST 8'h10
`define LMC_REG_RST 8'h00

`define LMC_BIT_FONT_USER 0
`define LMC_BIT_CHAR_H16 2
`define LMC_BIT_DUAL 3
`define LMC_BIT_COMP_OFF 5
`define LMC_BIT_DISP_ON 0
`define LMC_BIT_PWR_SAVE 0
`define LMC_SCROLL_MSB 2

`define LMC_CMD_LAST 3'h7

`endif

// ### core/lmc_text_mix.v
`timescale 1ns/100ps
`include "lmc_defines.vh"

module lmc_text_mix (
   input wire clk_i,
   input wire rst_b_i,
   input wire [7:0] text_i,
   input wire [7:0] graph_i,
   input wire [`LMC_SCROLL_MSB:0] scroll_i,
   input wire blank_text_i,
   input wire line_start_i,
   output reg [7:0] pixel_o
);

   reg [7:0] prev_text;
   wire [7:0] eff_text;
   wire [15:0] pair;
   wire [15:0] shifted;
   wire [7:0] scrolled;

   // Text row above the top edge is empty under origin compensation
   assign eff_text = blank_text_i ? 8'h00 : text_i;
   assign pair = {prev_text, eff_text};
   // Right shift pulls low bits of the previous byte in from the left
   assign shifted = pair >> scroll_i;
   assign scrolled = shifted[7:0];

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_text <= 8'h00;
         pixel_o <= 8'h00;
      end else begin
         // Clearing at line start keeps the left edge free of old pixels
         prev_text <= line_start_i ? 8'h00 : eff_text;
         // Exclusive-OR gives inverse text over the graphics layer
         pixel_o <= scrolled ^ graph_i;
      end
   end

endmodule // lmc_text_mix

// ### core/lmc_config.v
// Function
// - Memory configuration write restarts timing generator and blanks display.
// - In indirect mode that write also ends power save.
// - Configure command loads registers 00h-07h in order; same side effects.
// - Bit 5 low enables origin compensation, high disables it.
// - Compensation shifts text one pixel row against graphics layer.
// - Pixel scroll moves text right by one to seven pixels.
// - Memory configuration resets to 10h.
// - Bit 3 low selects single panel, high selects dual panel.
// - Block starts come from pairs 0Bh/0Ch, 0Eh/0Fh, 11h/12h.
// - Fourth block start used only in dual panel mode.
// - Cursor moves continuously over the whole screen in both modes.
// - Bit 2 selects 8 or 16 pixel character height.
// - Bit 0 selects fixed font or user font memory.
`timescale 1ns/100ps
`include "lmc_defines.vh"

module lmc_config (
   input wire clk_i,
   input wire rst_b_i,
   input wire [`LMC_ADDR_W-1:0] addr_i,
   input wire [7:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rd_data_o,
   input wire indirect_i,
   input wire cmd_start_i,
   input wire cmd_valid_i,
   input wire [7:0] cmd_data_i,
   input wire cursor_step_i,
   input wire [7:0] text_data_i,
   input wire [7:0] graph_data_i,
   output reg timing_restart_o,
   output reg display_on_o,
   output reg power_save_o,
   output reg dual_panel_o,
   output reg font_user_o,
   output reg frame_start_o,
   output reg line_start_o,
   output reg [7:0] line_o,
   output reg [7:0] col_o,
   output reg [3:0] char_row_o,
   output reg [15:0] text_start_o,
   output reg [15:0] graph_start_o,
   output reg [15:0] cursor_o,
   output wire [7:0] pixel_o
);

   reg [7:0] rf [0:`LMC_REG_CNT-1];
   reg [`LMC_IDX_W-1:0] cmd_idx;
   reg cmd_busy;
   reg [7:0] col;
   reg [7:0] line;

   wire bus_hit_wr;
   wire bus_hit_rd;
   wire [`LMC_IDX_W-1:0] bus_idx;
   wire cmd_take;
   wire any_we;
   wire [`LMC_IDX_W-1:0] we_idx;
   wire [7:0] we_data;
   wire cfg_write;

   wire [7:0] memcfg;
   wire comp_on;
   wire dual;
   wire char_h16;
   wire [7:0] row_bytes;
   wire [7:0] frame_h;
   wire [15:0] range;
   wire [15:0] start1;
   wire [15:0] start2;
   wire [15:0] start3;
   wire [15:0] start4;
   wire [15:0] curs_load;
   wire [24:0] screen_prod;
   wire [15:0] screen_end;

   wire last_col;
   wire last_line;
   wire upper_half;
   wire in_block1;
   wire [7:0] text_line;
   wire blank_text;

   // Decode shared by read and write paths
   function in_map;
      input [`LMC_ADDR_W-1:0] a;
      begin
         in_map = (a >= `LMC_BASE) &&
                  (a <= (`LMC_BASE + {10'h000, `LMC_IDX_LAST}));
      end
   endfunction

   function [`LMC_IDX_W-1:0] to_idx;
      input [`LMC_ADDR_W-1:0] a;
      reg [`LMC_ADDR_W-1:0] off;
      begin
         off = a - `LMC_BASE;
         to_idx = off[`LMC_IDX_W-1:0];
      end
   endfunction

   assign bus_hit_wr = wr_i && in_map(addr_i);
   assign bus_hit_rd = rd_i && in_map(addr_i);
   assign bus_idx = to_idx(addr_i);

   // Bus write wins a collision; the command byte of that cycle is lost
   assign cmd_take = cmd_busy && cmd_valid_i && !bus_hit_wr;
   assign any_we = bus_hit_wr || cmd_take;
   assign we_idx = bus_hit_wr ? bus_idx : cmd_idx;
   assign we_data = bus_hit_wr ? wr_data_i : cmd_data_i;
   assign cfg_write = any_we && (we_idx == `LMC_IDX_MEMCFG);

   assign memcfg = rf[`LMC_IDX_MEMCFG];
   assign comp_on = !memcfg[`LMC_BIT_COMP_OFF];
   assign dual = memcfg[`LMC_BIT_DUAL];
   assign char_h16 = memcfg[`LMC_BIT_CHAR_H16];
   assign row_bytes = rf[`LMC_IDX_ROW_BYTES];
   assign frame_h = rf[`LMC_IDX_FRAME_H];
   assign range = {rf[`LMC_IDX_RANGE_HI], rf[`LMC_IDX_RANGE_LO]};
   assign start1 = {rf[`LMC_IDX_B1_HI], rf[`LMC_IDX_B1_LO]};
   assign start2 = {rf[`LMC_IDX_B2_HI], rf[`LMC_IDX_B2_LO]};
   assign start3 = {rf[`LMC_IDX_B3_HI], rf[`LMC_IDX_B3_LO]};
   assign start4 = {rf[`LMC_IDX_B4_HI], rf[`LMC_IDX_B4_LO]};
   assign curs_load = {wr_data_i, rf[`LMC_IDX_CURS_LO]};

   // Screen spans range bytes per line times all lines of the frame
   assign screen_prod = range * ({1'b0, frame_h} + 9'h001);
   assign screen_end = start1 + screen_prod[15:0];

   assign last_col = (col >= row_bytes);
   assign last_line = (line >= frame_h);
   assign upper_half = (line <= rf[`LMC_IDX_B1_SIZE]);
   assign in_block1 = (line <= rf[`LMC_IDX_B1_SIZE]);

   // Text lags the graphics layer by one row; the top row shows no text
   assign text_line = comp_on ? (line - 8'h01) : line;
   assign blank_text = comp_on && (line == 8'h00);

   // Register file
   integer i;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (i = 0; i < `LMC_REG_CNT; i = i + 1) begin
            rf[i] <= `LMC_REG_RST;
         end
         rf[`LMC_IDX_MEMCFG] <= `LMC_MEMCFG_RST;
      end else begin
         for (i = 0; i < `LMC_REG_CNT; i = i + 1) begin
            if (any_we && (we_idx == i[`LMC_IDX_W-1:0])) begin
               rf[i] <= we_data;
            end
         end
         // Configuration write forces the display off even if the same
         // cycle writes the enable itself, which cannot happen here
         if (cfg_write) begin
            rf[`LMC_IDX_DISP_EN] <= `LMC_REG_RST;
            if (indirect_i) begin
               rf[`LMC_IDX_PWR_SAVE] <= `LMC_REG_RST;
            end
         end
      end
   end

   // Configure command: parameter bytes land in 00h..07h in order
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_busy <= 1'b0;
         cmd_idx <= `LMC_IDX_MEMCFG;
      end else if (cmd_start_i) begin
         cmd_busy <= 1'b1;
         cmd_idx <= `LMC_IDX_MEMCFG;
      end else if (cmd_take) begin
         if (cmd_idx == {3'h0, `LMC_CMD_LAST}) begin
            cmd_busy <= 1'b0;
            cmd_idx <= `LMC_IDX_MEMCFG;
         end else begin
            cmd_idx <= cmd_idx + 6'h01;
         end
      end
   end

   // Read data stand in the cycle after the strobe only
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_o <= 8'h00;
      end else if (bus_hit_rd) begin
         rd_data_o <= rf[bus_idx];
      end else begin
         rd_data_o <= 8'h00;
      end
   end

   // Timing generator: column and line counters
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         col <= 8'h00;
         line <= 8'h00;
         timing_restart_o <= 1'b0;
      end else begin
         timing_restart_o <= cfg_write;
         if (cfg_write) begin
            col <= 8'h00;
            line <= 8'h00;
         end else if (last_col) begin
            col <= 8'h00;
            line <= last_line ? 8'h00 : (line + 8'h01);
         end else begin
            col <= col + 8'h01;
         end
      end
   end

   // Status and mode outputs
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         display_on_o <= 1'b0;
         power_save_o <= 1'b0;
         dual_panel_o <= 1'b0;
         font_user_o <= 1'b0;
         frame_start_o <= 1'b0;
         line_start_o <= 1'b0;
         line_o <= 8'h00;
         col_o <= 8'h00;
         char_row_o <= 4'h0;
      end else begin
         display_on_o <= rf[`LMC_IDX_DISP_EN][`LMC_BIT_DISP_ON] &&
                         !rf[`LMC_IDX_PWR_SAVE][`LMC_BIT_PWR_SAVE] &&
                         !cfg_write;
         power_save_o <= rf[`LMC_IDX_PWR_SAVE][`LMC_BIT_PWR_SAVE];
         dual_panel_o <= dual;
         font_user_o <= memcfg[`LMC_BIT_FONT_USER];
         frame_start_o <= (col == 8'h00) && (line == 8'h00);
         line_start_o <= (col == 8'h00);
         line_o <= line;
         col_o <= col;
         char_row_o <= char_h16 ? text_line[3:0] :
                       {1'b0, text_line[2:0]};
      end
   end

   // Start address selection per line and drive mode
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         text_start_o <= 16'h0000;
         graph_start_o <= 16'h0000;
      end else if (dual) begin
         // Upper half uses blocks one and two, lower half three and four
         text_start_o <= upper_half ? start1 : start3;
         graph_start_o <= upper_half ? start2 : start4;
      end else begin
         // Block four is invalid in single panel mode and never read
         text_start_o <= in_block1 ? start1 : start3;
         graph_start_o <= start2;
      end
   end

   // Cursor walks linearly; no split at the panel boundary
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cursor_o <= 16'h0000;
      end else if (bus_hit_wr && (bus_idx == `LMC_IDX_CURS_HI)) begin
         cursor_o <= curs_load;
      end else if (cursor_step_i) begin
         if ((cursor_o + 16'h0001) >= screen_end) begin
            cursor_o <= start1;
         end else begin
            cursor_o <= cursor_o + 16'h0001;
         end
      end
   end

   lmc_text_mix u_mix (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .text_i(text_data_i),
      .graph_i(graph_data_i),
      .scroll_i(rf[`LMC_IDX_SCROLL][`LMC_SCROLL_MSB:0]),
      .blank_text_i(blank_text),
      .line_start_i(col == 8'h00),
      .pixel_o(pixel_o)
   );

endmodule // lmc_config

// ### tb/lmc_config_assertions.sv
`timescale 1ns/100ps
`include "lmc_defines.vh"
module lmc_cfg_chk (
   input wire clk_i,
   input wire rst_b_i,
   input wire [`LMC_ADDR_W-1:0] addr_i,
   input wire [7:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rd_data_o,
   input wire indirect_i,
   input wire cmd_start_i,
   input wire cmd_valid_i,
   input wire timing_restart_o,
   input wire display_on_o,
   input wire power_save_o,
   input wire dual_panel_o,
   input wire font_user_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire cfg_wr = wr_i && addr_i == `LMC_BASE;
   wire cmd_b = cmd_valid_i && !wr_i;
   reg touched;
   // Reset value only holds until something reloads the register
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         touched <= 1'b0;
      else if (cfg_wr || cmd_valid_i)
         touched <= 1'b1;
   end
   a_cfg_restart: assert property (cfg_wr |=> timing_restart_o)
      else $error("no restart after config write");
   a_cfg_blank: assert property (cfg_wr |=> !display_on_o)
      else $error("display on after config write");
   a_pwr_exit: assert property (cfg_wr && indirect_i ##1 !wr_i
      |=> !power_save_o) else $error("power save kept");
   a_cmd_restart: assert property (cmd_start_i ##1 cmd_b
      |=> timing_restart_o) else $error("no restart after command");
   a_cmd_pwr: assert property (cmd_start_i ##1 cmd_b && indirect_i
      ##1 !wr_i |=> !power_save_o) else $error("command kept power save");
   a_dual_sel: assert property (cfg_wr ##1 !wr_i && !cmd_valid_i
      |=> dual_panel_o == $past(wr_data_i[3], 2))
      else $error("panel drive mismatch");
   a_font_sel: assert property (cfg_wr ##1 !wr_i && !cmd_valid_i
      |=> font_user_o == $past(wr_data_i[0], 2))
      else $error("font select mismatch");
   a_rst_value: assert property (rd_i && addr_i == `LMC_BASE &&
      !touched |=> rd_data_o == `LMC_MEMCFG_RST)
      else $error("config reset value wrong");
   c_cfg: cover property (cfg_wr);
   c_ind: cover property (cfg_wr && indirect_i);
   c_cmd: cover property (cmd_start_i ##1 cmd_b);
endmodule // lmc_cfg_chk
bind lmc_config lmc_cfg_chk i_lmc_cfg_chk (.*);

// ### tb/lmc_host.sv
`timescale 1ns/100ps
module lmc_host (
   input wire clk_i,
   input wire [7:0] rd_data_i,
   output reg [15:0] addr_o,
   output reg [7:0] wr_data_o,
   output reg wr_o,
   output reg rd_o
);
   initial begin
      addr_o = 16'h0000;
      wr_data_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // Released data is inverted so a stale value never looks valid
   task wr(input [15:0] a, input [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wr_data_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wr_data_o <= ~d;
   endtask
   task rd(input [15:0] a, output [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 d = rd_data_i;
   endtask
   task panel(input [7:0] cfg, input [7:0] fr, input [7:0] sz);
      wr(16'h8004, 8'h03);
      wr(16'h8005, fr);
      wr(16'h800d, sz);
      wr(16'h8010, sz);
      wr(16'h8000, cfg & 8'h2d);
   endtask
endmodule // lmc_host

// ### tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, v) begin \
   samples_checked++; \
   if ((v) !== (e)) begin \
      num_errors++; \
      $display("Error %s exp %h got %h", n, e, v); \
   end \
end
module tb_top;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic indirect_i = 1'b0;
   logic cmd_start_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic cursor_step_i = 1'b0;
   logic [7:0] cmd_data_i = 8'h00;
   logic [7:0] text_data_i = 8'h00;
   logic [7:0] graph_data_i = 8'h00;
   wire [15:0] addr_i, text_start_o, graph_start_o, cursor_o;
   wire [7:0] wr_data_i, rd_data_o, line_o, col_o, pixel_o;
   wire wr_i, rd_i, timing_restart_o, display_on_o, power_save_o;
   wire dual_panel_o, font_user_o, frame_start_o, line_start_o;
   wire [3:0] char_row_o;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [7:0] d;
   lmc_host i_lmc_host (.clk_i(clk_i), .rd_data_i(rd_data_o),
      .addr_o(addr_i), .wr_data_o(wr_data_i), .wr_o(wr_i), .rd_o(rd_i));
   lmc_config i_lmc_config (.*);
   initial forever #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         complete_run;
      end
   end
   task complete_run;
      $display("Checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task rd_chk(input [15:0] a, input [7:0] e);
      i_lmc_host.rd(a, d);
      `CHK("rd_data_o", e, d)
   endtask
   task wait_at(input [8:0] ln);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (n < 3000 && !(col_o == 8'h02 && (ln[8] || line_o == ln[7:0])));
   endtask
   function [15:0] st(input [1:0] k);
      st = 16'h1211 + {2'b00, k, 4'h0, 2'b00, k, 4'h0};
   endfunction
   function [7:0] ror(input [2:0] s);
      logic [15:0] w;
      w = {8'hc3, 8'hc3} >> s;
      ror = w[7:0] ^ 8'h0f;
   endfunction
   task t_cfg;
      i_lmc_host.wr(16'h8009, 8'h01);
      tick(3);
      `CHK("display_on_o", 1'b1, display_on_o)
      i_lmc_host.wr(16'h8000, 8'h29);
      #1;
      `CHK("timing_restart_o", 1'b1, timing_restart_o)
      `CHK("display_on_o", 1'b0, display_on_o)
      rd_chk(16'h8000, 8'h29);
      `CHK("dual_panel_o", 1'b1, dual_panel_o)
      `CHK("font_user_o", 1'b1, font_user_o)
      i_lmc_host.wr(16'h8000, 8'h20);
      tick(3);
      `CHK("dual_panel_o", 1'b0, dual_panel_o)
      `CHK("font_user_o", 1'b0, font_user_o)
   endtask
   task t_pwr(input logic ind, input logic e);
      @(posedge clk_i);
      indirect_i <= ind;
      i_lmc_host.wr(16'h8008, 8'h01);
      i_lmc_host.wr(16'h8000, 8'h20);
      tick(2);
      `CHK("power_save_o", e, power_save_o)
   endtask
   task t_cmd;
      int i;
      @(posedge clk_i);
      indirect_i <= 1'b1;
      cmd_start_i <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge clk_i);
         cmd_start_i <= 1'b0;
         cmd_valid_i <= 1'b1;
         cmd_data_i <= 8'h20 + i[7:0];
      end
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      tick(2);
      `CHK("power_save_o", 1'b0, power_save_o)
      for (i = 0; i < 8; i++)
         rd_chk(16'h8000 + i[15:0], 8'h20 + i[7:0]);
   endtask
   task t_panel(input [7:0] cfg, input [7:0] fr, input [7:0] sz);
      int i;
      logic up;
      i_lmc_host.panel(cfg, fr, sz);
      for (i = 0; i < 2 * fr + 2; i++) begin
         wait_at(9'h100);
         up = line_o <= sz;
         `CHK("text_start", st(up ? 2'd0 : 2'd2), text_start_o)
         `CHK("graph_start", st(up || !cfg[3] ? 2'd1 : 2'd3),
            graph_start_o)
         `CHK("char_row_o", line_o[2:0], char_row_o[2:0])
         if (cfg[2])
            `CHK("char_row_o", line_o[3], char_row_o[3])
      end
   endtask
   task t_pixel;
      int s;
      @(posedge clk_i);
      text_data_i <= 8'hc3;
      graph_data_i <= 8'h0f;
      i_lmc_host.panel(8'h20, 8'h07, 8'h07);
      for (s = 1; s < 8; s++) begin
         i_lmc_host.wr(16'h801b, s[7:0]);
         wait_at(9'h100);
         wait_at(9'h100);
         `CHK("pixel_o", ror(s[2:0]), pixel_o)
      end
      i_lmc_host.wr(16'h801b, 8'h00);
      i_lmc_host.panel(8'h00, 8'h07, 8'h07);
      // Restarted generator shows line 0, column 0 one cycle later
      tick(1);
      `CHK("frame_start_o", 1'b1, frame_start_o)
      `CHK("line_start_o", 1'b1, line_start_o)
      wait_at(9'h000);
      `CHK("pixel_o", 8'h0f, pixel_o)
      `CHK("line_start_o", 1'b0, line_start_o)
      wait_at(9'h001);
      `CHK("pixel_o", ror(3'd0), pixel_o)
      `CHK("frame_start_o", 1'b0, frame_start_o)
   endtask
   task t_cursor(input [7:0] lo, input [15:0] e);
      i_lmc_host.wr(16'h801c, lo);
      i_lmc_host.wr(16'h801d, 8'h12);
      @(posedge clk_i);
      cursor_step_i <= 1'b1;
      @(posedge clk_i);
      cursor_step_i <= 1'b0;
      tick(2);
      `CHK("cursor_o", e, cursor_o)
   endtask
   initial begin
      int i;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_chk(16'h8000, 8'h10);
      rd_chk(16'h8009, 8'h00);
      rd_chk(16'h8030, 8'h00);
      t_cfg;
      t_pwr(1'b1, 1'b0);
      t_pwr(1'b0, 1'b1);
      t_cmd;
      for (i = 0; i < 4; i++) begin
         d = (i == 3) ? 8'h13 : 8'h0b + 8'h03 * i[7:0];
         i_lmc_host.wr({8'h80, d}, 8'h11 + {i[3:0], 4'h0});
         i_lmc_host.wr({8'h80, d + 8'h01}, 8'h12 + {i[3:0], 4'h0});
      end
      t_panel(8'h24, 8'h0f, 8'h05);
      t_panel(8'h28, 8'h07, 8'h03);
      t_pixel;
      i_lmc_host.wr(16'h8006, 8'h02);
      i_lmc_host.wr(16'h8007, 8'h00);
      t_cursor(8'h20, 16'h1211);
      i_lmc_host.panel(8'h28, 8'h07, 8'h03);
      t_cursor(8'h20, 16'h1211);
      t_cursor(8'h18, 16'h1219);
      complete_run;
   end
endmodule // tb_top
